// ==== sfmt_mem.sv ====
// Purpose: small table memory with registered read data
// Assumes: one write port, one read port, same clock
// Notes: no reset on contents; unwritten words are undefined
`timescale 1ns/10ps
`default_nettype none
module sfmt_mem #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 7
) (
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [ADDR_W-1:0] i_waddr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [ADDR_W-1:0] i_raddr,
    output logic [DATA_W-1:0] o_rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    always_ff @(posedge i_clk) begin
        if (i_ce && i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : sfmt_mem
`default_nettype wire

// ==== sfmt_node_model.sv ====
// Purpose: remote nodes delivering received sync frames, one pulse per slot
// Assumes: caller spaces frames at least four cycles apart
// Notes: between frames the id and arrival fields show inverted junk, never the last value
`timescale 1ns/10ps
`default_nettype none
module sfmt_node_model (
    input wire logic i_clk,
    output logic o_frame_valid,
    output logic o_frame_static,
    output logic [10:0] o_frame_id,
    output logic o_frame_ok_a,
    output logic o_frame_ok_b,
    output logic [15:0] o_arrival_a,
    output logic [15:0] o_arrival_b,
    output logic o_filter_pass
);
    initial begin
        {o_frame_valid, o_frame_static, o_frame_ok_a, o_frame_ok_b, o_filter_pass} = 5'h00;
        o_frame_id = 11'h555;
        o_arrival_a = 16'hA5A5;
        o_arrival_b = 16'h5A5A;
    end
    task automatic send(input logic [10:0] id, input logic st, input logic a, input logic b,
        input logic [15:0] ta, input logic [15:0] tb, input logic pass);
        @(posedge i_clk);
        {o_frame_valid, o_frame_static, o_frame_ok_a, o_frame_ok_b, o_filter_pass} <= {1'b1, st, a, b, pass};
        o_frame_id <= id;
        o_arrival_a <= ta;
        o_arrival_b <= tb;
        @(posedge i_clk);
        o_frame_valid <= 1'b0;
        o_frame_id <= ~id;
        o_arrival_a <= ~ta;
        o_arrival_b <= ~tb;
    endtask : send
endmodule : sfmt_node_model
`default_nettype wire

// ==== sfmt_offset.sv ====
// Purpose: nominal arrival offset for the own sync frame entry
// Assumes: configuration words stable while the result is used
// Notes: registered result, one cycle behind the inputs
`timescale 1ns/10ps
`default_nettype none
module sfmt_offset
    import sfmt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [15:0] i_nominal_macrotick_length,
    input wire logic [15:0] i_action_point_offset,
    input wire logic [15:0] i_start_sequence_length,
    input wire logic [15:0] i_bit_duration,
    input wire logic [15:0] i_delay_comp_chan_a,
    input wire logic [15:0] i_delay_comp_chan_b,
    output logic [15:0] o_offset
);
    logic [31:0] ap_prod;
    logic [31:0] tss_prod;
    logic [15:0] max_dc;
    logic [31:0] diff;
    assign ap_prod = i_nominal_macrotick_length * i_action_point_offset;
    assign tss_prod = i_start_sequence_length * i_bit_duration;
    assign max_dc = (i_delay_comp_chan_a > i_delay_comp_chan_b) ?
                    i_delay_comp_chan_a : i_delay_comp_chan_b;
    assign diff = ap_prod - tss_prod - {16'h0000, max_dc} - {16'h0000, SFMT_OFFSET_TRIM};
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_offset <= 16'h0000;
        end else if (i_ce) begin
            o_offset <= diff[15:0];
        end
    end
endmodule : sfmt_offset
`default_nettype wire

// ==== sfmt_pkg.sv ====
// Purpose: constants for the sync frame measurement tables
// Assumes: 16-bit register port, byte offsets as printed
// Notes: tables are read-only to software
package sfmt_pkg;
    localparam logic [9:0] SFMT_EVEN_CNT_OFF = 10'h33C;
    localparam logic [9:0] SFMT_ODD_CNT_OFF = 10'h33E;
    localparam logic [9:0] SFMT_EVEN_A_OFF = 10'h340;
    localparam logic [9:0] SFMT_EVEN_B_OFF = 10'h360;
    localparam logic [9:0] SFMT_EVEN_ID_OFF = 10'h380;
    localparam logic [9:0] SFMT_ODD_A_OFF = 10'h3A0;
    localparam logic [9:0] SFMT_ODD_B_OFF = 10'h3C0;
    localparam logic [9:0] SFMT_ODD_ID_OFF = 10'h3E0;
    localparam int SFMT_ENTRIES = 16;
    localparam int SFMT_IDX_W = 4;
    localparam int SFMT_ID_W = 11;
    localparam int SFMT_TIME_W = 16;
    localparam logic [15:0] SFMT_OFFSET_TRIM = 16'h0004;
    localparam logic [15:0] SFMT_INVALID_TIME = 16'h0000;
    localparam logic [3:0] SFMT_CNT_NONSYNC = 4'h0;
    localparam logic [3:0] SFMT_CNT_SYNC = 4'h1;
    // table select codes for the shared memory
    localparam logic [2:0] SFMT_T_EVEN_A = 3'h0;
    localparam logic [2:0] SFMT_T_EVEN_B = 3'h1;
    localparam logic [2:0] SFMT_T_EVEN_ID = 3'h2;
    localparam logic [2:0] SFMT_T_ODD_A = 3'h3;
    localparam logic [2:0] SFMT_T_ODD_B = 3'h4;
    localparam logic [2:0] SFMT_T_ODD_ID = 3'h5;
endpackage : sfmt_pkg

// ==== sfmt_tables.sv ====
// Purpose: sync frame identifier, arrival and count tables per cycle parity
// Assumes: protocol engine supplies one-cycle event pulses on i_clk
// Notes: all table locations are read-only; software writes are ignored
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module sfmt_tables
    import sfmt_pkg::*;
#(
    parameter int ENTRIES = SFMT_ENTRIES
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // register port
    input wire logic [9:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // configuration
    input wire logic i_sync_transmit_config,
    input wire logic [10:0] i_own_sync_id,
    input wire logic i_filter_enable,
    input wire logic [15:0] i_nominal_macrotick_length,
    input wire logic [15:0] i_action_point_offset,
    input wire logic [15:0] i_start_sequence_length,
    input wire logic [15:0] i_bit_duration,
    input wire logic [15:0] i_delay_comp_chan_a,
    input wire logic [15:0] i_delay_comp_chan_b,
    // protocol state events
    input wire logic i_enter_sched_init,
    input wire logic i_enter_coll_resolve,
    input wire logic i_normal_op,
    input wire logic i_odd_nit_start,
    input wire logic i_even_cycle_end,
    input wire logic i_cycle_odd,
    // received sync frame, one pulse at end of slot
    input wire logic i_frame_valid,
    input wire logic i_frame_static,
    input wire logic [10:0] i_frame_id,
    input wire logic i_frame_ok_a,
    input wire logic i_frame_ok_b,
    input wire logic [15:0] i_arrival_a,
    input wire logic [15:0] i_arrival_b,
    input wire logic i_filter_pass,
    // status
    output logic [3:0] o_even_count,
    output logic [3:0] o_odd_count
);
    // ==========================================================
    // types and state
    typedef enum logic [3:0] {
        SFMT_IDLE = 4'b0001,
        SFMT_OWN_A = 4'b0010,
        SFMT_OWN_B = 4'b0100,
        SFMT_OWN_ID = 4'b1000
    } sfmt_wr_e;

    sfmt_wr_e wr_state_reg;
    sfmt_wr_e wr_state_next;
    logic [3:0] even_cnt_reg;
    logic [3:0] odd_cnt_reg;
    logic own_odd_reg;
    logic own_both_reg;
    logic [15:0] own_offset;
    logic [15:0] fr_time_a_reg;
    logic [15:0] fr_time_b_reg;
    logic [10:0] fr_id_reg;
    logic fr_odd_reg;
    logic [3:0] fr_idx_reg;
    logic [1:0] fr_phase_reg;
    logic accept;
    logic clr_even;
    logic clr_odd;
    logic [3:0] clr_value;
    logic mem_we;
    logic [6:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [6:0] mem_raddr;
    logic [15:0] mem_rdata;
    logic rd_d_reg;
    logic rd_cnt_reg;
    logic [15:0] rd_cnt_val_reg;

    function automatic logic [6:0] sfmt_addr(input logic [2:0] tsel, input logic [3:0] idx);
        sfmt_addr = {tsel, idx};
    endfunction : sfmt_addr

    // ==========================================================
    // acceptance and clearing
    // filter gate
    assign accept = i_frame_valid && i_frame_static && (i_frame_ok_a || i_frame_ok_b) &&
                    (!i_filter_enable || i_filter_pass);
    assign clr_even = i_enter_sched_init || i_enter_coll_resolve ||
                      (i_normal_op && i_odd_nit_start);
    assign clr_odd = i_enter_sched_init || i_enter_coll_resolve ||
                     (i_normal_op && i_even_cycle_end);
    assign clr_value = i_sync_transmit_config ? SFMT_CNT_SYNC : SFMT_CNT_NONSYNC;

    sfmt_offset u_offset (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_nominal_macrotick_length(i_nominal_macrotick_length),
        .i_action_point_offset(i_action_point_offset),
        .i_start_sequence_length(i_start_sequence_length),
        .i_bit_duration(i_bit_duration),
        .i_delay_comp_chan_a(i_delay_comp_chan_a),
        .i_delay_comp_chan_b(i_delay_comp_chan_b),
        .o_offset(own_offset)
    );

    // ==========================================================
    // counters
    // per parity count
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            even_cnt_reg <= SFMT_CNT_NONSYNC;
        end else if (i_ce) begin
            // a clear and a frame in one cycle: clear wins, frame belongs to the old cycle
            if (clr_even) begin
                even_cnt_reg <= clr_value;
            end else if (accept && !i_cycle_odd && even_cnt_reg != 4'hF) begin
                even_cnt_reg <= even_cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            odd_cnt_reg <= SFMT_CNT_NONSYNC;
        end else if (i_ce) begin
            if (clr_odd) begin
                odd_cnt_reg <= clr_value;
            end else if (accept && i_cycle_odd && odd_cnt_reg != 4'hF) begin
                odd_cnt_reg <= odd_cnt_reg + 4'h1;
            end
        end
    end

    assign o_even_count = even_cnt_reg;
    assign o_odd_count = odd_cnt_reg;

    // ==========================================================
    // table writer: own entry sequence, then frame writes
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            own_odd_reg <= 1'b0;
            own_both_reg <= 1'b0;
        end else if (i_ce && i_sync_transmit_config && (clr_even || clr_odd)) begin
            own_odd_reg <= clr_odd && !clr_even;
            own_both_reg <= clr_odd && clr_even;
        end else if (i_ce && wr_state_reg == SFMT_OWN_ID) begin
            // both counts cleared: even entry first, then a second pass for odd
            own_odd_reg <= own_both_reg;
            own_both_reg <= 1'b0;
        end
    end

    always_comb begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            SFMT_IDLE: begin
                if (i_sync_transmit_config && (clr_even || clr_odd)) begin
                    wr_state_next = SFMT_OWN_A;
                end
            end
            SFMT_OWN_A: wr_state_next = SFMT_OWN_B;
            SFMT_OWN_B: wr_state_next = SFMT_OWN_ID;
            SFMT_OWN_ID: wr_state_next = own_both_reg ? SFMT_OWN_A : SFMT_IDLE;
            default: wr_state_next = SFMT_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wr_state_reg <= SFMT_IDLE;
        end else if (i_ce) begin
            wr_state_reg <= wr_state_next;
        end
    end

    // captured frame, written over three cycles (A, B, id)
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            fr_phase_reg <= 2'h0;
            fr_time_a_reg <= 16'h0000;
            fr_time_b_reg <= 16'h0000;
            fr_id_reg <= 11'h000;
            fr_odd_reg <= 1'b0;
            fr_idx_reg <= 4'h0;
        end else if (i_ce) begin
            // a frame dropped by a clear must not land in the fresh table
            if (accept && !(i_cycle_odd ? clr_odd : clr_even) &&
                !(i_cycle_odd ? odd_cnt_reg == 4'hF : even_cnt_reg == 4'hF)) begin
                fr_phase_reg <= 2'h1;
                fr_time_a_reg <= i_frame_ok_a ? i_arrival_a : SFMT_INVALID_TIME;
                fr_time_b_reg <= i_frame_ok_b ? i_arrival_b : SFMT_INVALID_TIME;
                fr_id_reg <= i_frame_id;
                fr_odd_reg <= i_cycle_odd;
                fr_idx_reg <= i_cycle_odd ? odd_cnt_reg : even_cnt_reg;
            end else if (fr_phase_reg != 2'h0 && wr_state_reg == SFMT_IDLE) begin
                fr_phase_reg <= (fr_phase_reg == 2'h3) ? 2'h0 : fr_phase_reg + 2'h1;
            end
        end
    end

    always_comb begin
        mem_we = 1'b0;
        mem_waddr = 7'h00;
        mem_wdata = 16'h0000;
        case (wr_state_reg)
            SFMT_OWN_A: begin
                mem_we = 1'b1;
                mem_waddr = sfmt_addr(own_odd_reg ? SFMT_T_ODD_A : SFMT_T_EVEN_A, 4'h0);
                mem_wdata = own_offset;
            end
            SFMT_OWN_B: begin
                mem_we = 1'b1;
                mem_waddr = sfmt_addr(own_odd_reg ? SFMT_T_ODD_B : SFMT_T_EVEN_B, 4'h0);
                mem_wdata = own_offset;
            end
            SFMT_OWN_ID: begin
                mem_we = 1'b1;
                mem_waddr = sfmt_addr(own_odd_reg ? SFMT_T_ODD_ID : SFMT_T_EVEN_ID, 4'h0);
                mem_wdata = {5'h00, i_own_sync_id};
            end
            SFMT_IDLE: begin
                if (fr_phase_reg == 2'h1) begin
                    mem_we = 1'b1;
                    mem_waddr = sfmt_addr(fr_odd_reg ? SFMT_T_ODD_A : SFMT_T_EVEN_A, fr_idx_reg);
                    mem_wdata = fr_time_a_reg;
                end else if (fr_phase_reg == 2'h2) begin
                    mem_we = 1'b1;
                    mem_waddr = sfmt_addr(fr_odd_reg ? SFMT_T_ODD_B : SFMT_T_EVEN_B, fr_idx_reg);
                    mem_wdata = fr_time_b_reg;
                end else if (fr_phase_reg == 2'h3) begin
                    mem_we = 1'b1;
                    mem_waddr = sfmt_addr(fr_odd_reg ? SFMT_T_ODD_ID : SFMT_T_EVEN_ID,
                                          fr_idx_reg);
                    mem_wdata = {5'h00, fr_id_reg};
                end
            end
            default: begin
                mem_we = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // register read port
    always_comb begin
        mem_raddr = 7'h7F;
        if (i_addr >= SFMT_EVEN_A_OFF && i_addr < SFMT_EVEN_B_OFF) begin
            mem_raddr = sfmt_addr(SFMT_T_EVEN_A, i_addr[4:1]);
        end else if (i_addr >= SFMT_EVEN_B_OFF && i_addr < SFMT_EVEN_ID_OFF) begin
            mem_raddr = sfmt_addr(SFMT_T_EVEN_B, i_addr[4:1]);
        end else if (i_addr >= SFMT_EVEN_ID_OFF && i_addr < SFMT_ODD_A_OFF) begin
            mem_raddr = sfmt_addr(SFMT_T_EVEN_ID, i_addr[4:1]);
        end else if (i_addr >= SFMT_ODD_A_OFF && i_addr < SFMT_ODD_B_OFF) begin
            mem_raddr = sfmt_addr(SFMT_T_ODD_A, i_addr[4:1]);
        end else if (i_addr >= SFMT_ODD_B_OFF && i_addr < SFMT_ODD_ID_OFF) begin
            mem_raddr = sfmt_addr(SFMT_T_ODD_B, i_addr[4:1]);
        end else if (i_addr >= SFMT_ODD_ID_OFF) begin
            mem_raddr = sfmt_addr(SFMT_T_ODD_ID, i_addr[4:1]);
        end
    end

    sfmt_mem #(.DATA_W(16), .ADDR_W(7)) u_mem (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(mem_raddr),
        .o_rdata(mem_rdata)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd_d_reg <= 1'b0;
            rd_cnt_reg <= 1'b0;
            rd_cnt_val_reg <= 16'h0000;
        end else if (i_ce) begin
            rd_d_reg <= i_rd && i_addr >= SFMT_EVEN_A_OFF && !i_addr[0];
            rd_cnt_reg <= i_rd && (i_addr == SFMT_EVEN_CNT_OFF || i_addr == SFMT_ODD_CNT_OFF);
            rd_cnt_val_reg <= {12'h000,
                               (i_addr == SFMT_ODD_CNT_OFF) ? odd_cnt_reg : even_cnt_reg};
        end
    end

    assign o_rdata = rd_cnt_reg ? rd_cnt_val_reg : (rd_d_reg ? mem_rdata : 16'h0000);

    logic unused_ok;
    assign unused_ok = i_wr ^ (^i_wdata);
endmodule : sfmt_tables
`default_nettype wire

// ==== sfmt_tables_sva.sv ====
// Purpose: concurrent checks on the counter and read port of the sync tables
// Assumes: one clock, synchronous active-low reset
// Notes: table contents are judged by the bench; counters are judged here
`timescale 1ns/10ps
`default_nettype none
module sfmt_tables_sva
    import sfmt_pkg::*;
#(
    parameter int ENTRIES = SFMT_ENTRIES
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [9:0] i_addr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic i_sync_transmit_config,
    input wire logic i_filter_enable,
    input wire logic i_enter_sched_init,
    input wire logic i_enter_coll_resolve,
    input wire logic i_normal_op,
    input wire logic i_odd_nit_start,
    input wire logic i_even_cycle_end,
    input wire logic i_cycle_odd,
    input wire logic i_frame_valid,
    input wire logic i_frame_static,
    input wire logic i_frame_ok_a,
    input wire logic i_frame_ok_b,
    input wire logic i_filter_pass,
    input wire logic [3:0] o_even_count,
    input wire logic [3:0] o_odd_count
);
    // ==========
    // accept and clear decode
    logic acc;
    logic clr_e;
    logic clr_o;
    assign acc = i_ce & i_frame_valid & i_frame_static & (i_frame_ok_a | i_frame_ok_b)
        & (~i_filter_enable | i_filter_pass);
    assign clr_e = i_ce & (i_enter_sched_init | i_enter_coll_resolve | (i_normal_op & i_odd_nit_start));
    assign clr_o = i_ce & (i_enter_sched_init | i_enter_coll_resolve | (i_normal_op & i_even_cycle_end));
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ==========
    // assertions
    chk_rdata_idle: assert property (!$past(i_rd && i_ce) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    chk_even_cnt_read: assert property ($past(i_rd && i_ce) && $past(i_addr) == SFMT_EVEN_CNT_OFF
        |-> o_rdata == {12'h000, $past(o_even_count)}) else $error("even count read wrong");
    chk_odd_cnt_read: assert property ($past(i_rd && i_ce) && $past(i_addr) == SFMT_ODD_CNT_OFF
        |-> o_rdata == {12'h000, $past(o_odd_count)}) else $error("odd count read wrong");
    chk_even_incr: assert property (acc && !i_cycle_odd && !clr_e && !clr_o
        && int'(o_even_count) < ENTRIES - 1 |=> o_even_count == $past(o_even_count) + 4'h1
        && $stable(o_odd_count)) else $error("even count did not step once");
    chk_odd_incr: assert property (acc && i_cycle_odd && !clr_e && !clr_o
        && int'(o_odd_count) < ENTRIES - 1 |=> o_odd_count == $past(o_odd_count) + 4'h1
        && $stable(o_even_count)) else $error("odd count did not step once");
    chk_count_hold: assert property (!acc && !clr_e && !clr_o
        |=> $stable(o_even_count) && $stable(o_odd_count)) else $error("count moved without cause");
    chk_state_clear: assert property (i_ce && (i_enter_sched_init || i_enter_coll_resolve)
        |=> o_even_count == {3'h0, $past(i_sync_transmit_config)}
        && o_odd_count == {3'h0, $past(i_sync_transmit_config)}) else $error("state clear wrong");
    chk_even_nit_clear: assert property (i_ce && i_normal_op && i_odd_nit_start
        |=> o_even_count == {3'h0, $past(i_sync_transmit_config)}) else $error("even clear wrong");
    chk_odd_end_clear: assert property (i_ce && i_normal_op && i_even_cycle_end
        |=> o_odd_count == {3'h0, $past(i_sync_transmit_config)}) else $error("odd clear wrong");
    chk_count_saturate: assert property (acc && !clr_e && !clr_o
        && int'(i_cycle_odd ? o_odd_count : o_even_count) == ENTRIES - 1
        |=> $stable(o_even_count) && $stable(o_odd_count)) else $error("full count moved");
    cover property (acc && !i_cycle_odd);
    cover property (acc && i_cycle_odd);
    cover property (i_ce && i_enter_sched_init && i_sync_transmit_config);
    cover property (acc && o_even_count == 4'hF);
endmodule : sfmt_tables_sva
bind sfmt_tables sfmt_tables_sva #(.ENTRIES(ENTRIES)) u_sfmt_sva (.i_clk, .i_rst_b, .i_ce, .i_addr,
    .i_rd, .o_rdata, .i_sync_transmit_config, .i_filter_enable, .i_enter_sched_init,
    .i_enter_coll_resolve, .i_normal_op, .i_odd_nit_start, .i_even_cycle_end, .i_cycle_odd,
    .i_frame_valid, .i_frame_static, .i_frame_ok_a, .i_frame_ok_b, .i_filter_pass,
    .o_even_count, .o_odd_count);
`default_nettype wire

// ==== testbench.sv ====
// Purpose: self-checking bench for the sync frame measurement tables
// Assumes: config changed only between clears
// Notes: table writes land within six cycles, so reads wait a fixed span
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); end end
module testbench
    import sfmt_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b, wr, rd, sync_cfg, filt_en, sched, coll, norm, nit, eend, odd;
    logic [9:0] addr;
    logic [10:0] own_id;
    logic [15:0] wdata, nml, apo, tss, bd, dca, dcb, rdata;
    logic [3:0] even_cnt, odd_cnt;
    logic f_valid, f_static, f_a, f_b, f_pass;
    logic [10:0] f_id;
    logic [15:0] t_a, t_b;
    int fail_count = 0;
    int total_checks = 0;
    logic ce = 1'b1;
    always #20 clk = ~clk;
    sfmt_node_model node (.i_clk(clk), .o_frame_valid(f_valid), .o_frame_static(f_static),
        .o_frame_id(f_id), .o_frame_ok_a(f_a), .o_frame_ok_b(f_b), .o_arrival_a(t_a),
        .o_arrival_b(t_b), .o_filter_pass(f_pass));
    sfmt_tables DUT (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sync_transmit_config(sync_cfg),
        .i_own_sync_id(own_id), .i_filter_enable(filt_en), .i_nominal_macrotick_length(nml),
        .i_action_point_offset(apo), .i_start_sequence_length(tss), .i_bit_duration(bd),
        .i_delay_comp_chan_a(dca), .i_delay_comp_chan_b(dcb), .i_enter_sched_init(sched),
        .i_enter_coll_resolve(coll), .i_normal_op(norm), .i_odd_nit_start(nit),
        .i_even_cycle_end(eend), .i_cycle_odd(odd), .i_frame_valid(f_valid),
        .i_frame_static(f_static), .i_frame_id(f_id), .i_frame_ok_a(f_a), .i_frame_ok_b(f_b),
        .i_arrival_a(t_a), .i_arrival_b(t_b), .i_filter_pass(f_pass), .o_even_count(even_cnt),
        .o_odd_count(odd_cnt));
    // ==========
    // bus and event helpers
    task automatic bus_rd(input logic [9:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask : bus_rd
    task automatic bus_wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    // order of m: schedule init, collision resolve, odd idle start, even cycle end
    task automatic evt(input logic [3:0] m);
        @(posedge clk);
        {sched, coll, nit, eend} <= m;
        @(posedge clk);
        {sched, coll, nit, eend} <= 4'h0;
        repeat (8) @(posedge clk);
    endtask : evt
    task automatic frame(input logic [10:0] id, input logic st, input logic a, input logic b,
        input logic [15:0] ta, input logic [15:0] tb, input logic pass);
        node.send(id, st, a, b, ta, tb, pass);
        repeat (5) @(posedge clk);
    endtask : frame
    function automatic logic [15:0] off_exp();
        return nml * apo - tss * bd - ((dca > dcb) ? dca : dcb) - SFMT_OFFSET_TRIM;
    endfunction : off_exp
    // ==========
    // scenarios
    task automatic t_own_entry();
        @(posedge clk);
        sync_cfg <= 1'b1;
        norm <= 1'b1;
        evt(4'h1);
        bus_rd(SFMT_ODD_CNT_OFF, 16'h0001);
        bus_rd(SFMT_ODD_ID_OFF, {5'h00, own_id});
        bus_rd(SFMT_ODD_A_OFF, off_exp());
        bus_rd(SFMT_ODD_B_OFF, off_exp());
        @(posedge clk);
        dca <= 16'h0009;
        evt(4'h8);
        bus_rd(SFMT_EVEN_CNT_OFF, 16'h0001);
        bus_rd(SFMT_EVEN_ID_OFF, {5'h00, own_id});
        bus_rd(SFMT_EVEN_A_OFF, off_exp());
        bus_rd(SFMT_EVEN_B_OFF, off_exp());
        bus_rd(SFMT_ODD_A_OFF, off_exp());
    endtask : t_own_entry
    task automatic t_even_frames();
        frame(11'h005, 1'b1, 1'b1, 1'b0, 16'h1234, 16'h5555, 1'b1);
        frame(11'h7FF, 1'b1, 1'b1, 1'b1, 16'h8001, 16'hFFFF, 1'b1);
        frame(11'h0AA, 1'b0, 1'b1, 1'b1, 16'h0101, 16'h0101, 1'b1);
        frame(11'h0AB, 1'b1, 1'b0, 1'b0, 16'h0102, 16'h0102, 1'b1);
        @(posedge clk);
        filt_en <= 1'b1;
        frame(11'h0AC, 1'b1, 1'b1, 1'b1, 16'h0103, 16'h0103, 1'b0);
        frame(11'h123, 1'b1, 1'b1, 1'b1, 16'h0104, 16'h0105, 1'b1);
        @(posedge clk);
        filt_en <= 1'b0;
        bus_rd(SFMT_EVEN_A_OFF + 10'h002, 16'h1234);
        bus_rd(SFMT_EVEN_B_OFF + 10'h002, SFMT_INVALID_TIME);
        bus_rd(SFMT_EVEN_ID_OFF + 10'h002, 16'h0005);
        bus_rd(SFMT_EVEN_A_OFF + 10'h004, 16'h8001);
        bus_rd(SFMT_EVEN_B_OFF + 10'h004, 16'hFFFF);
        bus_rd(SFMT_EVEN_ID_OFF + 10'h004, 16'h07FF);
        bus_rd(SFMT_EVEN_ID_OFF + 10'h006, 16'h0123);
        bus_rd(SFMT_EVEN_CNT_OFF, 16'h0004);
        `CHK(even_cnt, 4'h4)
    endtask : t_even_frames
    task automatic t_odd_and_readonly();
        @(posedge clk);
        odd <= 1'b1;
        frame(11'h044, 1'b1, 1'b0, 1'b1, 16'h0333, 16'h0222, 1'b1);
        @(posedge clk);
        ce <= 1'b0;
        frame(11'h045, 1'b1, 1'b1, 1'b1, 16'h0444, 16'h0444, 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        odd <= 1'b0;
        bus_rd(SFMT_ODD_A_OFF + 10'h002, SFMT_INVALID_TIME);
        bus_rd(SFMT_ODD_B_OFF + 10'h002, 16'h0222);
        bus_rd(SFMT_ODD_CNT_OFF, 16'h0002);
        `CHK(odd_cnt, 4'h2)
        bus_wr(SFMT_EVEN_CNT_OFF, 16'hFFFF);
        bus_wr(SFMT_EVEN_ID_OFF + 10'h002, 16'h0000);
        bus_rd(SFMT_EVEN_CNT_OFF, 16'h0004);
        bus_rd(SFMT_EVEN_ID_OFF + 10'h002, 16'h0005);
        bus_rd(10'h100, 16'h0000);
        bus_rd(10'h341, 16'h0000);
    endtask : t_odd_and_readonly
    task automatic t_saturate_and_clear();
        @(posedge clk);
        sync_cfg <= 1'b0;
        norm <= 1'b0;
        evt(4'h4);
        bus_rd(SFMT_ODD_CNT_OFF, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            frame(11'(i + 1), 1'b1, 1'b1, 1'b0, 16'h0100 + 16'(i), 16'h0000, 1'b1);
        end
        bus_rd(SFMT_EVEN_CNT_OFF, 16'h000F);
        bus_rd(SFMT_EVEN_A_OFF + 10'h01C, 16'h010E);
        bus_rd(SFMT_EVEN_ID_OFF + 10'h01C, 16'h000F);
        evt(4'h2);
        bus_rd(SFMT_EVEN_CNT_OFF, 16'h000F);
        @(posedge clk);
        norm <= 1'b1;
        odd <= 1'b1;
        frame(11'h050, 1'b1, 1'b1, 1'b1, 16'h0050, 16'h0051, 1'b1);
        @(posedge clk);
        odd <= 1'b0;
        evt(4'h2);
        bus_rd(SFMT_EVEN_CNT_OFF, 16'h0000);
        bus_rd(SFMT_ODD_CNT_OFF, 16'h0001);
        evt(4'h1);
        bus_rd(SFMT_ODD_CNT_OFF, 16'h0000);
    endtask : t_saturate_and_clear
    // ==========
    // verdict and run control
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        $display("CHECK FAILED t=%0t run did not complete", $time);
        tally_and_finish();
    end
    initial begin
        {rst_b, wr, rd, sync_cfg, filt_en, sched, coll, norm, nit, eend, odd} = 11'h000;
        addr = 10'h000;
        wdata = 16'h0000;
        own_id = 11'h2A5;
        nml = 16'h0028;
        apo = 16'h0005;
        tss = 16'h0009;
        bd = 16'h0008;
        dca = 16'h0003;
        dcb = 16'h0007;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        bus_rd(SFMT_EVEN_CNT_OFF, 16'h0000);
        t_own_entry();
        t_even_frames();
        t_odd_and_readonly();
        t_saturate_and_clear();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
